// >>> hw/dlk_interlock.sv
// Operation
// RQ1: forced-opening only if door present, must-open
// RQ2: release request is active high
// RQ3: permit only when closed and locked
// RQ4: request drops permit before solenoid acts
// RQ5: solenoid drive after release delay elapses
// RQ6: feedback must follow drive within timeout
// RQ7: timeout not below solenoid activation time
// RQ8: door open while locked is error
// RQ9: door sensor reports every actual opening
// RQ10: request gone, door closed: relock
// RQ11: permit returns after locked and closed
// RQ12: error when door never opened
// RQ13: error output rises at cycle end
// RQ14: spring option: energise solenoid to release
// RQ15: sample inputs once per cycle, count cycles
// RQ16: reset holds outputs low until secured
module dlk_interlock
    import dlk_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        ce_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic [31:0]      prdata_o,
    // sensor pins
    input  wire logic        release_req_i,
    input  wire logic        door_closed_i,
    input  wire logic        lock_fb_i,
    // actuator and status
    output logic             solenoid_drive_o,
    output logic             permit_o,
    output logic             error_o,
    output logic             irq_o
);
    ////////////////////////////////////////////////////////////////////////////
    dlk_sense_if sense ();

    dlk_sync u_sync (
        .clk_i      (clk_i),
        .reset_i    (reset_i),
        .ce_i       (ce_i),
        .req_pin_i  (release_req_i),
        .door_pin_i (door_closed_i),
        .fb_pin_i   (lock_fb_i),
        .sense      (sense)
    );

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [DLK_CTRL_W-1:0] ctrl_r;
    logic [DLK_EV_W-1:0]   irq_st_r;
    logic [DLK_EV_W-1:0]   irq_msk_r;
    logic [DLK_CNT_W-1:0]  delay_r;
    logic [DLK_CNT_W-1:0]  fbto_r;
    logic [31:0]           prdata_r;

    dlk_state_t            state_r;
    dlk_state_t            state_nxt;
    logic                  drive_r;
    logic                  permit_r;
    logic                  error_r;
    logic                  opened_r;
    logic                  fb_prev_r;

    logic                  wr_acc;
    logic                  rd_acc;
    logic                  addr_ok;
    logic [31:0]           rd_mux;
    logic [DLK_EV_W-1:0]   ev;

    assign pready_o  = 1'b1;
    assign wr_acc    = psel_i & penable_i & pwrite_i & ce_i;
    assign rd_acc    = psel_i & ~penable_i & ~pwrite_i;
    assign addr_ok   = (paddr_i == DLK_OFF_CTRL) | (paddr_i == DLK_OFF_STATUS) |
                       (paddr_i == DLK_OFF_IRQ_ST) | (paddr_i == DLK_OFF_IRQ_MSK) |
                       (paddr_i == DLK_OFF_DELAY) | (paddr_i == DLK_OFF_FBTO);
    assign pslverr_o = psel_i & penable_i & ~addr_ok;
    assign prdata_o  = prdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // configuration view
    logic no_door;
    logic must_open;
    logic spring;
    logic mode_ok;
    logic locked;
    logic closed;
    logic req;
    logic fb_moved;

    assign no_door   = ctrl_r[DLK_CTRL_NO_DOOR];
    assign must_open = ctrl_r[DLK_CTRL_MUST_OPEN];
    assign spring    = ctrl_r[DLK_CTRL_SPRING];
    assign mode_ok   = ~no_door & must_open;                           // [RQ1]
    assign req       = sense.req;                                      // [RQ2]
    assign closed    = sense.door_closed;
    // spring lock: feedback high = energised, locked when de-energised
    assign locked    = spring ? ~sense.lock_fb : sense.lock_fb;        // [RQ14]
    assign fb_moved  = sense.lock_fb ^ fb_prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // timers
    logic delay_clr;
    logic delay_done;
    logic fbto_clr;
    logic fbto_done;

    assign delay_clr = (state_r != DLK_ST_DELAY);
    assign fbto_clr  = (state_r != DLK_ST_RELEASING) & (state_r != DLK_ST_RELOCKING);

    dlk_timer u_delay (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .ce_i    (ce_i),
        .clear_i (delay_clr),
        .limit_i (delay_r),
        .done_o  (delay_done)
    );

    dlk_timer u_fbto (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .ce_i    (ce_i),
        .clear_i (fbto_clr),
        .limit_i (fbto_r),
        .done_o  (fbto_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // supervisor state machine, one step per system cycle [RQ15]
    logic to_fault;
    logic not_opened;

    assign not_opened = (state_r == DLK_ST_RELOCKING) & locked & closed & ~opened_r;
    // a door opened during the release delay is still opened against a held lock
    assign to_fault   = (state_r == DLK_ST_FAULT) ? 1'b0 :
                        (((state_r == DLK_ST_LOCKED) | (state_r == DLK_ST_DELAY)) &
                         ~closed);                                     // [RQ8]

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            DLK_ST_IDLE:
                if (mode_ok & locked & closed & ~req)
                    state_nxt = DLK_ST_LOCKED;                         // [RQ16]
            DLK_ST_LOCKED:
                if (~closed & locked)
                    state_nxt = DLK_ST_FAULT;                          // [RQ8]
                else if (req)
                    state_nxt = DLK_ST_DELAY;                          // [RQ4]
            DLK_ST_DELAY:
                if (~closed & locked)
                    state_nxt = DLK_ST_FAULT;                          // [RQ8]
                else if (~req)
                    state_nxt = DLK_ST_LOCKED;
                else if (delay_done)
                    state_nxt = DLK_ST_RELEASING;                      // [RQ5]
            DLK_ST_RELEASING:
                if (fb_moved)
                    state_nxt = DLK_ST_OPENED;
                else if (fbto_done)
                    state_nxt = DLK_ST_FAULT;                          // [RQ6]
            DLK_ST_OPENED:
                if (~req & closed)
                    state_nxt = DLK_ST_RELOCKING;                      // [RQ10]
            DLK_ST_RELOCKING:
                if (locked & closed)
                    state_nxt = DLK_ST_LOCKED;                         // [RQ11]
                else if (fbto_done)
                    state_nxt = DLK_ST_FAULT;                          // [RQ6]
            DLK_ST_FAULT:
                // leave once software clears and guard is secured, or at once when mode_ok drops
                if (ctrl_r[DLK_CTRL_ERR_CLR] & locked & closed & ~req)
                    state_nxt = DLK_ST_IDLE;
            default:
                state_nxt = DLK_ST_IDLE;
        endcase
        if (!mode_ok)
            state_nxt = DLK_ST_IDLE;
    end

    assign ev[DLK_EV_PERMIT_RISE] = (state_nxt == DLK_ST_LOCKED) & ~permit_r;
    assign ev[DLK_EV_FB_TIMEOUT]  = fbto_done & ~fbto_clr;
    assign ev[DLK_EV_NOT_OPENED]  = not_opened;
    assign ev[DLK_EV_OPEN_LOCKED] = to_fault & locked;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state_r   <= DLK_ST_IDLE;
            drive_r   <= 1'b0;
            permit_r  <= 1'b0;
            error_r   <= 1'b0;
            opened_r  <= 1'b0;
            fb_prev_r <= 1'b0;
        end
        else if (ce_i)
        begin
            state_r   <= state_nxt;
            fb_prev_r <= sense.lock_fb;
            // energise to release (spring); otherwise de-energise to release
            drive_r   <= ((state_nxt == DLK_ST_RELEASING) | (state_nxt == DLK_ST_OPENED))
                         ^ ~spring;                                    // [RQ14]
            if (state_nxt == DLK_ST_IDLE | state_nxt == DLK_ST_FAULT)
                drive_r <= ~spring;
            permit_r  <= (state_nxt == DLK_ST_LOCKED) & ~req & locked & closed; // [RQ3]
            if (state_nxt == DLK_ST_DELAY)
                opened_r <= 1'b0;
            else if (~closed)
                opened_r <= 1'b1;
            if (state_nxt == DLK_ST_FAULT | not_opened)
                error_r <= ctrl_r[DLK_CTRL_ERR_EN];                    // [RQ12]
            else if (ctrl_r[DLK_CTRL_ERR_CLR])
                error_r <= 1'b0;
        end
    end

    assign solenoid_drive_o = drive_r;
    assign permit_o         = permit_r;
    assign error_o          = error_r;                                 // [RQ13]
    assign irq_o            = |(irq_st_r & irq_msk_r);

    ////////////////////////////////////////////////////////////////////////////
    // register file
    always_comb
    begin
        rd_mux = 32'h0;
        case (paddr_i)
            DLK_OFF_CTRL:    rd_mux = 32'(ctrl_r);
            DLK_OFF_STATUS:  rd_mux = {24'h0, 1'b0, state_r, error_r, drive_r,
                                       permit_r, opened_r};
            DLK_OFF_IRQ_ST:  rd_mux = 32'(irq_st_r);
            DLK_OFF_IRQ_MSK: rd_mux = 32'(irq_msk_r);
            DLK_OFF_DELAY:   rd_mux = delay_r;
            DLK_OFF_FBTO:    rd_mux = fbto_r;
            default:         rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ctrl_r    <= DLK_CTRL_RST;
            irq_st_r  <= '0;
            irq_msk_r <= '0;
            delay_r   <= DLK_DELAY_CYC;
            fbto_r    <= DLK_FBTO_CYC;
            prdata_r  <= 32'h0;
        end
        else
        begin
            if (rd_acc)
                prdata_r <= rd_mux;
            if (ce_i)
            begin
                // set beats write-one-to-clear
                irq_st_r <= (irq_st_r & ~((wr_acc & paddr_i == DLK_OFF_IRQ_ST) ?
                            pwdata_i[DLK_EV_W-1:0] : '0)) | ev;
                if (ctrl_r[DLK_CTRL_ERR_CLR])
                    ctrl_r[DLK_CTRL_ERR_CLR] <= 1'b0;
            end
            if (wr_acc)
            begin
                case (paddr_i)
                    DLK_OFF_CTRL:    ctrl_r    <= pwdata_i[DLK_CTRL_W-1:0];
                    DLK_OFF_IRQ_MSK: irq_msk_r <= pwdata_i[DLK_EV_W-1:0];
                    DLK_OFF_DELAY:   delay_r   <= pwdata_i;
                    DLK_OFF_FBTO:    fbto_r    <= pwdata_i; // keep >= solenoid time [RQ7]
                    default:         ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    permit_safe_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ3]
        permit_r |-> (locked & closed) || $past(locked & closed))
        else $error("permit high without locked and closed guard");

    req_drop_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ4]
        (ce_i & req & state_r == DLK_ST_LOCKED) |=> !permit_r)
        else $error("permit not dropped on release request");

    drive_wait_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ5]
        (state_r == DLK_ST_DELAY && !delay_done) |-> drive_r == ~spring)
        else $error("solenoid moved before release delay");

    fb_timeout_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ6]
        (ce_i & state_r == DLK_ST_RELEASING & fbto_done & !fb_moved & mode_ok)
        |=> state_r == DLK_ST_FAULT && !permit_r)
        else $error("feedback timeout not flagged");

    open_lock_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ8]
        (ce_i & mode_ok & (state_r == DLK_ST_LOCKED | state_r == DLK_ST_DELAY) &
         ~closed & locked)
        |=> state_r == DLK_ST_FAULT ##1 !permit_r)
        else $error("open door while locked not faulted");

    relock_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ10]
        (ce_i & mode_ok & state_r == DLK_ST_OPENED & ~req & closed)
        |=> drive_r == ~spring)
        else $error("solenoid not returned to lock");

    not_open_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ12]
        (ce_i & not_opened & ctrl_r[DLK_CTRL_ERR_EN] & mode_ok) |=> error_r)
        else $error("missing door opening not reported");

    mode_gate_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ1]
        (ce_i & !mode_ok) |=> state_r == DLK_ST_IDLE && !permit_r)
        else $error("supervisor active outside forced-opening mode");
endmodule : dlk_interlock

// >>> hw/dlk_pkg.sv
package dlk_pkg;

    // apb register byte offsets
    localparam logic [7:0] DLK_OFF_CTRL    = 8'h00;
    localparam logic [7:0] DLK_OFF_STATUS  = 8'h04;
    localparam logic [7:0] DLK_OFF_IRQ_ST  = 8'h08;
    localparam logic [7:0] DLK_OFF_IRQ_MSK = 8'h0c;
    localparam logic [7:0] DLK_OFF_DELAY   = 8'h10;
    localparam logic [7:0] DLK_OFF_FBTO    = 8'h14;

    // control bit positions
    localparam int DLK_CTRL_NO_DOOR    = 0;
    localparam int DLK_CTRL_MUST_OPEN  = 1;
    localparam int DLK_CTRL_SPRING     = 2;
    localparam int DLK_CTRL_ERR_EN     = 3;
    localparam int DLK_CTRL_ERR_CLR    = 4;
    localparam int DLK_CTRL_W          = 5;
    localparam logic [DLK_CTRL_W-1:0] DLK_CTRL_RST = 5'h0e;

    // interrupt event bit positions
    localparam int DLK_EV_PERMIT_RISE = 0;
    localparam int DLK_EV_FB_TIMEOUT  = 1;
    localparam int DLK_EV_NOT_OPENED  = 2;
    localparam int DLK_EV_OPEN_LOCKED = 3;
    localparam int DLK_EV_W           = 4;

    // timing: release delay 500 ms, feedback timeout 100 ms at 40 MHz
    localparam int  DLK_CLK_HZ         = 40000000;
    localparam int  DLK_DELAY_MS       = 500;
    localparam int  DLK_FBTO_MS        = 100;
    localparam int  DLK_CNT_W          = 32;
    localparam logic [DLK_CNT_W-1:0] DLK_DELAY_CYC =
        DLK_CNT_W'((64'(DLK_CLK_HZ) * DLK_DELAY_MS) / 1000);
    localparam logic [DLK_CNT_W-1:0] DLK_FBTO_CYC =
        DLK_CNT_W'((64'(DLK_CLK_HZ) * DLK_FBTO_MS) / 1000);

    typedef enum logic [2:0] {
        DLK_ST_IDLE,
        DLK_ST_LOCKED,
        DLK_ST_DELAY,
        DLK_ST_RELEASING,
        DLK_ST_OPENED,
        DLK_ST_RELOCKING,
        DLK_ST_FAULT
    } dlk_state_t;

endpackage : dlk_pkg

// >>> hw/dlk_sense_if.sv
interface dlk_sense_if;
    logic req;
    logic door_closed;
    logic lock_fb;
    modport src (output req, output door_closed, output lock_fb);
    modport dst (input req, input door_closed, input lock_fb);
endinterface : dlk_sense_if

// >>> hw/dlk_sync.sv
module dlk_sync
    import dlk_pkg::*;
(
    // clock
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic ce_i,
    // raw pins
    input  wire logic req_pin_i,
    input  wire logic door_pin_i,
    input  wire logic fb_pin_i,
    // synchronised
    dlk_sense_if.src  sense
);
    logic [2:0] meta_r;
    logic [2:0] sync_r;

    // two stages; first stage read only by the second
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            meta_r <= 3'h0;
            sync_r <= 3'h0;
        end
        else if (ce_i)
        begin
            meta_r <= {fb_pin_i, door_pin_i, req_pin_i};
            sync_r <= meta_r;
        end
    end

    assign sense.req         = sync_r[0];
    assign sense.door_closed = sync_r[1];
    assign sense.lock_fb     = sync_r[2];
endmodule : dlk_sync

// >>> hw/dlk_timer.sv
module dlk_timer
    import dlk_pkg::*;
(
    // clock
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    input  wire logic                 ce_i,
    // control
    input  wire logic                 clear_i,
    input  wire logic [DLK_CNT_W-1:0] limit_i,
    // result
    output logic                      done_o
);
    logic [DLK_CNT_W-1:0] cnt_r;
    logic                 at_lim;

    assign at_lim = (cnt_r >= limit_i);
    assign done_o = at_lim;

    // saturates at limit so done stays high until cleared
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            cnt_r <= '0;
        else if (ce_i)
        begin
            if (clear_i)
                cnt_r <= '0;
            else if (!at_lim)
                cnt_r <= cnt_r + DLK_CNT_W'(1);
        end
    end
endmodule : dlk_timer

// >>> bench/dlk_guard_model.sv
module dlk_guard_model
#(
    parameter int FB_LAT = 6
)
(
    // clock
    input  wire logic clk_i,
    // solenoid side
    input  wire logic drive_i,
    input  wire logic stuck_i,
    output logic      lock_fb_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] lag_r;

    initial
    begin
        lag_r     = 8'h00;
        lock_fb_o = 1'b0;
    end

    // armature lags the drive, always inside the programmed timeout
    // stuck_i models a jammed armature that never answers
    always @(posedge clk_i)
    begin
        if (stuck_i || lock_fb_o == drive_i)
            lag_r <= 8'h00;
        else if (lag_r == 8'(FB_LAT - 1))
        begin
            lock_fb_o <= drive_i;
            lag_r     <= 8'h00;
        end
        else
            lag_r <= lag_r + 8'h01;
    end
endmodule : dlk_guard_model

// >>> bench/door_interlock_forced_opening_tb_top.sv
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end

module door_interlock_forced_opening_tb_top
    import dlk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [7:0] a; logic [31:0] d; logic e;} dlk_row_t;

    logic        clk_i, reset_i, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata_o, q;
    logic        pready_o, pslverr_o, qe, release_req, door_closed, stuck;
    logic        lock_fb, solenoid_drive_o, permit_o, error_o, irq_o;
    int          err_total, n_tests, n1, n2;
    dlk_row_t    rows [5];

    dlk_interlock dut_u (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
        .release_req_i(release_req), .door_closed_i(door_closed), .lock_fb_i(lock_fb),
        .solenoid_drive_o(solenoid_drive_o), .permit_o(permit_o), .error_o(error_o),
        .irq_o(irq_o));

    dlk_guard_model #(.FB_LAT(6)) guard_u (.clk_i(clk_i), .drive_i(solenoid_drive_o),
        .stuck_i(stuck), .lock_fb_o(lock_fb));

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        q  = prdata_o;
        qe = pslverr_o;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // 0 permit, 1 drive, 2 error
    task automatic wait_sig(input int which, input logic val, output int n);
        logic s;
        n = 0;
        do
        begin
            @(negedge clk_i);
            n++;
            s = (which == 0) ? permit_o : (which == 1) ? solenoid_drive_o : error_o;
        end
        while (s !== val && n < 400);
        if (n >= 400)
        begin
            err_total++;
            $display("[ERR] wait sig %0d exp %b got %b", which, val, s);
        end
    endtask : wait_sig

    task automatic pins(input logic r, input logic d);
        @(posedge clk_i);
        release_req <= r;
        door_closed <= d;
    endtask : pins

    // one release and relock; opened says whether the door is swung
    task automatic cycle(input logic opened);
        pins(1'b1, 1'b1);
        wait_sig(0, 1'b0, n1);
        `CHK("drive early", 1'b0, solenoid_drive_o)
        wait_sig(1, 1'b1, n2);
        `CHK("delay held", 1'b1, (n1 + n2) >= 10)
        repeat (12) @(posedge clk_i);
        if (opened)
        begin
            pins(1'b1, 1'b0);
            repeat (8) @(posedge clk_i);
            pins(1'b1, 1'b1);
            repeat (4) @(posedge clk_i);
        end
        pins(1'b0, 1'b1);
        wait_sig(1, 1'b0, n1);
        `CHK("err mid", 1'b0, error_o)
        `CHK("permit mid", 1'b0, permit_o)
        wait_sig(0, 1'b1, n1);
        repeat (3) @(negedge clk_i);
    endtask : cycle

    task automatic clear_fault;
        apb(1'b1, DLK_OFF_CTRL, 32'h0000001e);
        apb(1'b1, DLK_OFF_IRQ_ST, 32'h0000000f);
        wait_sig(0, 1'b1, n1);
    endtask : clear_fault

    task automatic stop_test;
        if (err_total == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        stop_test();
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, release_req, stuck} = '0;
        door_closed = 1'b1;
        reset_i = 1'b1;
        err_total = 0;
        n_tests = 0;
        rows[0] = '{DLK_OFF_CTRL, 32'h0000000e, 1'b0};
        rows[1] = '{DLK_OFF_DELAY, 32'h01312d00, 1'b0};
        rows[2] = '{DLK_OFF_FBTO, 32'h003d0900, 1'b0};
        rows[3] = '{8'h18, 32'h00000000, 1'b1};
        rows[4] = '{8'hfc, 32'h00000000, 1'b1};
        repeat (16) @(posedge clk_i);
        @(negedge clk_i);
        `CHK("reset outs", 3'b000, {permit_o, solenoid_drive_o, error_o})
        @(posedge clk_i);
        reset_i <= 1'b0;
        foreach (rows[i])
        begin
            apb(1'b0, rows[i].a, 32'h0);
            `CHK("reg read", rows[i].d, q)
            `CHK("reg slverr", rows[i].e, qe)
        end
        apb(1'b1, DLK_OFF_DELAY, 32'h0000000a);
        apb(1'b1, DLK_OFF_FBTO, 32'h00000028);
        apb(1'b1, DLK_OFF_IRQ_MSK, 32'h0000000f);
        wait_sig(0, 1'b1, n1);
        apb(1'b1, DLK_OFF_IRQ_ST, 32'h0000000f);
        // normal cycle with the door swung
        cycle(1'b1);
        `CHK("err opened", 1'b0, error_o)
        apb(1'b0, DLK_OFF_IRQ_ST, 32'h0);
        `CHK("irq no open", 1'b0, q[DLK_EV_NOT_OPENED])
        // door never opened: error at the end of the cycle
        cycle(1'b0);
        `CHK("err unopened", 1'b1, error_o)
        apb(1'b0, DLK_OFF_IRQ_ST, 32'h0);
        `CHK("irq not open", 1'b1, q[DLK_EV_NOT_OPENED])
        `CHK("irq unmasked", 1'b1, irq_o)
        apb(1'b1, DLK_OFF_IRQ_MSK, 32'h00000000);
        @(negedge clk_i);
        `CHK("irq masked", 1'b0, irq_o)
        apb(1'b1, DLK_OFF_IRQ_MSK, 32'h0000000f);
        clear_fault();
        `CHK("irq cleared", 1'b0, irq_o)
        `CHK("err cleared", 1'b0, error_o)
        // jammed armature: feedback never follows
        stuck <= 1'b1;
        pins(1'b1, 1'b1);
        wait_sig(1, 1'b1, n1);
        repeat (60) @(negedge clk_i);
        `CHK("permit fbto", 1'b0, permit_o)
        `CHK("err fbto", 1'b1, error_o)
        apb(1'b0, DLK_OFF_IRQ_ST, 32'h0);
        `CHK("irq fbto", 1'b1, q[DLK_EV_FB_TIMEOUT])
        pins(1'b0, 1'b1);
        repeat (6) @(posedge clk_i);
        clear_fault();
        stuck <= 1'b0;
        // door forced open while locked
        pins(1'b0, 1'b0);
        wait_sig(0, 1'b0, n1);
        `CHK("open lock delay", 1'b1, n1 <= 4)
        `CHK("err open locked", 1'b1, error_o)
        apb(1'b0, DLK_OFF_IRQ_ST, 32'h0);
        `CHK("irq open locked", 1'b1, q[DLK_EV_OPEN_LOCKED])
        pins(1'b0, 1'b1);
        repeat (6) @(posedge clk_i);
        clear_fault();
        // power-to-lock: drive held high while locked
        apb(1'b1, DLK_OFF_CTRL, 32'h0000000a);
        wait_sig(1, 1'b1, n1);
        apb(1'b1, DLK_OFF_CTRL, 32'h0000000e);
        wait_sig(1, 1'b0, n1);
        wait_sig(0, 1'b1, n1);
        // supervisor must idle outside the forced-opening mode
        apb(1'b1, DLK_OFF_CTRL, 32'h0000000f);
        repeat (2) @(negedge clk_i);
        `CHK("permit no door", 1'b0, permit_o)
        apb(1'b1, DLK_OFF_CTRL, 32'h0000000e);
        wait_sig(0, 1'b1, n1);
        apb(1'b1, DLK_OFF_CTRL, 32'h0000000c);
        repeat (2) @(negedge clk_i);
        `CHK("permit no must", 1'b0, permit_o)
        apb(1'b1, DLK_OFF_CTRL, 32'h0000000e);
        wait_sig(0, 1'b1, n1);
        // reset in mid-run drops permit, drive and error
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        `CHK("reset mid", 3'b000, {permit_o, solenoid_drive_o, error_o})
        @(posedge clk_i);
        reset_i <= 1'b0;
        wait_sig(0, 1'b1, n1);
        stop_test();
    end
endmodule : door_interlock_forced_opening_tb_top
